// ===== verilog/su_defines.svh
/*
  Offsets, reset values and timing counts of the serial unit.
  Assumes it is included by bare name from the package, the checker and the bench.
*/
`ifndef SU_DEFINES_SVH
`define SU_DEFINES_SVH

// Register offsets on the plain register port
`define SU_OFS_STOP 3'h0
`define SU_OFS_CTRL 3'h1
`define SU_OFS_STAT 3'h2
`define SU_OFS_TXD 3'h3
`define SU_OFS_RXD 3'h4
`define SU_OFS_BAUD 3'h5
`define SU_OFS_PORT 3'h6

// Reset values
`define SU_RST_STOP 8'h01
`define SU_RST_CTRL 8'h00
`define SU_RST_STAT 8'h84
`define SU_RST_TXD 8'hFF
`define SU_RST_RXD 8'h00
`define SU_RST_BAUD 8'h00
`define SU_RST_PORT 8'h01

// Timing counts of the asynchronous receiver
`define SU_OVERSAMPLE 5'd16
`define SU_SAMPLE_PULSE 4'd7
`define SU_DATA_BITS 4'd8

`endif

// ===== verilog/su_pkg.sv
/*
  Types shared by the serial unit: control and status layouts, states.
  Assumes su_defines.svh is on the include path.
*/
package su_pkg;
  `include "su_defines.svh"

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic tx_empty_irq_on;
    logic rx_irq_on;
    logic tx_on;
    logic rx_on;
    logic parity_odd;
    logic tx_done_irq_on;
    logic parity_on;
    logic sync_mode;
  } su_ctrl_s;

  // Status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_fault_flag;
    logic parity_fault_flag;
    logic tx_finished_flag;
    logic [1:0] unused;
  } su_stat_s;

  // Interrupt request lines, highest priority first
  typedef struct packed {
    logic rx_fault_irq;
    logic rx_full_irq;
    logic tx_empty_irq;
    logic tx_done_irq;
  } su_irq_s;

  typedef enum logic {SU_TX_IDLE, SU_TX_RUN} su_tx_state_e;
  typedef enum logic {SU_RX_IDLE, SU_RX_RUN} su_rx_state_e;
endpackage

// ===== verilog/su_serial_unit.sv
/*
  Serial unit: one channel with async and clocked synchronous modes,
  status flags, four interrupt request lines and transfer controller hooks.
  Assumes software on a plain register port, a transfer controller that
  marks its own accesses, and a peer whose pins are asynchronous to
  ref_clk_i. Clocked synchronous mode uses the peer's clock on sclk_i.
*/
// Function
// R1: Four separate request lines: rx fault, rx full, tx empty, tx done.
// R2: Tx empty request follows the tx buffer empty flag, gated by enable.
// R3: Tx done request only while finished flag and its enable are set.
// R4: Rx full request follows the receive full flag, gated by enable.
// R5: Rx fault request when overrun, framing or parity flag is set.
// R6: Only tx empty and rx full requests may start the transfer controller.
// R7: Controller access clears flag only with select 0 and nonzero count.
// R8: Default priority rx fault, rx full, tx empty, tx done; channel 0 first.
// R9: Clearing tx buffer empty also clears the tx finished flag.
// R10: Unit starts stopped; other registers reachable only after stop cleared.
// R11: Tx buffer empty sets when holding buffer moves into shift buffer.
// R12: Holding buffer writes always accepted; writer checks empty flag first.
// R13: Overrun keeps old receive data; rx full and overrun flags both set.
// R14: Framing or parity fault stores data, rx full stays 0, flags set.
// R15: Break sets framing fault again, reception keeps running.
// R16: Before tx enable the output pin shows the port output value.
// R17: Clearing tx enable resets transmitter at once; pin returns to port.
// R18: Synchronous mode: no transmit start while any receive fault flag set.
// R19: Clearing rx enable leaves the fault flags unchanged.
// R20: Async receive at 16x bit rate, sampled at eighth base pulse.
// R21: Peer holds off external clock edges five cycles after buffer write.
// R22: Controller reading received data must be started by rx full request.
// R23: Tx empty request asserts only while its enable bit is 1.
// R24: Rx full and rx fault requests share the single receive enable.
// R25: Requests are levels, dropping the cycle after the flag clears.
module su_serial_unit
  import su_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Transfer controller qualifiers for the current access
  input wire logic xfer_access_i,
  input wire logic xfer_irq_select_i,
  input wire logic xfer_count_nonzero_i,
  // Serial pins
  input wire logic rxd_i,
  input wire logic sclk_i,
  output logic txd_o,
  // Interrupt requests and priority
  output su_irq_s irq_o,
  output logic [1:0] xfer_start_o,
  output logic [2:0] irq_top_o
);

  // Registers
  logic stop;
  su_ctrl_s ctrl;
  su_stat_s stat;
  logic [7:0] tx_holding_buffer;
  logic [7:0] rx_holding_buffer;
  logic [7:0] baud;
  logic port_output_value;

  // Pin synchronisers and edge history
  logic [1:0] rxd_sync;
  logic [2:0] sclk_sync;
  logic rx_in;
  logic sclk_rise;
  logic sclk_fall;

  // Baud divider
  logic [7:0] baud_cnt;
  logic tick;

  // Transmitter
  su_tx_state_e tx_state;
  logic [10:0] tx_shift_buffer;
  logic [3:0] tx_bits;
  logic [3:0] tx_sub;
  logic tx_load;
  logic tx_end;
  logic tx_step;

  // Receiver
  su_rx_state_e rx_state;
  logic [7:0] rx_shift_buffer;
  logic [3:0] rx_idx;
  logic [3:0] rx_sub;
  logic rx_par;
  logic rx_done;
  logic rx_fer_ev;
  logic rx_per_ev;

  // Decoded accesses; all but the stop register are dead while stopped
  logic live;
  logic wr_stop;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_txd;
  logic wr_baud;
  logic wr_port;
  logic rd_rxd;
  logic xfer_clear;
  logic any_fault;
  logic sync_blocked;
  logic [3:0] rx_last;
  logic par_bad;
  logic [7:0] rd_mux;
  su_irq_s next_irq;

  assign live = !stop; // [R10]
  assign wr_stop = wr_i && addr_i == `SU_OFS_STOP;
  assign wr_ctrl = wr_i && live && addr_i == `SU_OFS_CTRL;
  assign wr_stat = wr_i && live && addr_i == `SU_OFS_STAT;
  assign wr_txd = wr_i && live && addr_i == `SU_OFS_TXD; // [R12]
  assign wr_baud = wr_i && live && addr_i == `SU_OFS_BAUD;
  assign wr_port = wr_i && live && addr_i == `SU_OFS_PORT;
  assign rd_rxd = rd_i && live && addr_i == `SU_OFS_RXD;
  // Controller clears the flag only in this configuration
  assign xfer_clear = xfer_access_i && !xfer_irq_select_i
                      && xfer_count_nonzero_i; // [R7]

  assign any_fault = stat.overrun_flag | stat.framing_fault_flag
                     | stat.parity_fault_flag;
  // Synchronous mode refuses to move while a fault is pending
  assign sync_blocked = ctrl.sync_mode && any_fault; // [R18]

  // Edge detection only looks past the first synchroniser stage
  assign rx_in = rxd_sync[1];
  assign sclk_rise = sclk_sync[1] && !sclk_sync[2];
  assign sclk_fall = !sclk_sync[1] && sclk_sync[2];

  // Read mux; unmapped reads, and stopped reads other than the stop register, return zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (addr_i == `SU_OFS_STOP)
      rd_mux = {7'h00, stop};
    else if (live)
    begin
      case (addr_i)
        `SU_OFS_CTRL: rd_mux = ctrl;
        `SU_OFS_STAT: rd_mux = stat;
        `SU_OFS_TXD: rd_mux = tx_holding_buffer;
        `SU_OFS_RXD: rd_mux = rx_holding_buffer;
        `SU_OFS_BAUD: rd_mux = baud;
        `SU_OFS_PORT: rd_mux = {7'h00, port_output_value};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Request levels; both receive requests share one enable
  assign next_irq.rx_fault_irq = any_fault && ctrl.rx_irq_on; // [R5] [R24]
  assign next_irq.rx_full_irq = stat.rx_full_flag
                                && ctrl.rx_irq_on; // [R4] [R24]
  assign next_irq.tx_empty_irq = stat.tx_buffer_empty_flag
                                 && ctrl.tx_empty_irq_on; // [R2] [R23]
  assign next_irq.tx_done_irq = stat.tx_finished_flag
                                && ctrl.tx_done_irq_on; // [R3]

  // Async frame length in bits after the start bit
  assign rx_last = ctrl.parity_on ? 4'd10 : 4'd9;
  assign par_bad = (^{rx_shift_buffer, rx_par}) != ctrl.parity_odd;

  // Transmit stepping: one bit per 16 ticks, or per falling peer clock
  assign tx_step = ctrl.sync_mode ? sclk_fall
                   : (tick && tx_sub == 4'hF);
  assign tx_load = tx_state == SU_TX_IDLE && live && ctrl.tx_on
                   && !stat.tx_buffer_empty_flag && !sync_blocked;
  assign tx_end = tx_state == SU_TX_RUN && tx_step && tx_bits == 4'd1;

  // Register port writes and read data for one cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stop <= 1'(`SU_RST_STOP);
      ctrl <= `SU_RST_CTRL;
      tx_holding_buffer <= `SU_RST_TXD;
      baud <= `SU_RST_BAUD;
      port_output_value <= 1'(`SU_RST_PORT);
      rdata_o <= 8'h00;
    end
    else
    begin
      if (wr_stop)
        stop <= wdata_i[0];
      if (wr_ctrl)
        ctrl <= wdata_i;
      if (wr_txd)
        tx_holding_buffer <= wdata_i;
      if (wr_baud)
        baud <= wdata_i;
      if (wr_port)
        port_output_value <= wdata_i[0];
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // Two-flop synchronisers on pins from the peer
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rxd_sync <= 2'b11;
      sclk_sync <= 3'b111;
    end
    else
    begin
      rxd_sync <= {rxd_sync[0], rxd_i};
      sclk_sync <= {sclk_sync[1:0], sclk_i};
    end
  end

  // Base clock at 16x bit rate as a one-cycle enable
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      baud_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= baud_cnt == baud; // [R20]
      baud_cnt <= (baud_cnt == baud) ? 8'h00 : baud_cnt + 8'h01;
    end
  end

  // Transmitter; dropping enable or stopping aborts any frame at once
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_state <= SU_TX_IDLE;
      tx_shift_buffer <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_sub <= 4'h0;
    end
    else if (!ctrl.tx_on || stop)
    begin
      tx_state <= SU_TX_IDLE; // [R17]
      tx_shift_buffer <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_sub <= 4'h0;
    end
    else if (tx_load || (tx_end && !stat.tx_buffer_empty_flag
                         && !sync_blocked))
    begin
      // Async frame: start, data LSB first, optional parity, stop; sync mode sends the data bits only
      tx_state <= SU_TX_RUN;
      tx_sub <= 4'h0;
      if (ctrl.sync_mode)
      begin
        tx_shift_buffer <= {3'b111, tx_holding_buffer};
        tx_bits <= `SU_DATA_BITS;
      end
      else if (ctrl.parity_on)
      begin
        tx_shift_buffer <= {1'b1, (^tx_holding_buffer) ^ ctrl.parity_odd,
                            tx_holding_buffer, 1'b0};
        tx_bits <= 4'd11;
      end
      else
      begin
        tx_shift_buffer <= {2'b11, tx_holding_buffer, 1'b0};
        tx_bits <= 4'd10;
      end
    end
    else if (tx_state == SU_TX_RUN)
    begin
      if (tick && !ctrl.sync_mode)
        tx_sub <= tx_sub + 4'h1;
      if (tx_end)
        tx_state <= SU_TX_IDLE; // Sync mode keeps MSB on the pin
      else if (tx_step)
      begin
        tx_shift_buffer <= {1'b1, tx_shift_buffer[10:1]};
        tx_bits <= tx_bits - 4'h1;
      end
    end
  end

  // Pin is port controlled until the transmitter is enabled
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      txd_o <= 1'b1;
    else
      txd_o <= (ctrl.tx_on && !stop) ? tx_shift_buffer[0]
               : port_output_value; // [R16] [R17]
  end

  // Receiver; a break just runs frame after frame with framing faults
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_state <= SU_RX_IDLE;
      rx_shift_buffer <= 8'h00;
      rx_idx <= 4'h0;
      rx_sub <= 4'h0;
      rx_par <= 1'b0;
      rx_done <= 1'b0;
      rx_fer_ev <= 1'b0;
      rx_per_ev <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      rx_fer_ev <= 1'b0;
      rx_per_ev <= 1'b0;
      // Disabled or blocked: bit position restarts, so a half-received
      // async frame cannot skew the next clocked byte
      if (!ctrl.rx_on || stop || sync_blocked)
      begin
        rx_state <= SU_RX_IDLE;
        rx_idx <= 4'h0;
      end
      else if (ctrl.sync_mode)
      begin
        // Clocked synchronous: sample on rising peer clock
        if (sclk_rise)
        begin
          rx_shift_buffer[rx_idx[2:0]] <= rx_in;
          rx_idx <= (rx_idx == 4'd7) ? 4'h0 : rx_idx + 4'h1;
          rx_done <= rx_idx == 4'd7;
        end
      end
      else
      begin
        case (rx_state)
          SU_RX_IDLE:
          begin
            rx_idx <= 4'h0;
            if (tick && !rx_in)
            begin
              rx_state <= SU_RX_RUN; // Start edge counts as pulse one
              rx_sub <= 4'h1;
            end
          end
          SU_RX_RUN:
          begin
            if (tick)
            begin
              rx_sub <= rx_sub + 4'h1;
              if (rx_sub == `SU_SAMPLE_PULSE) // [R20]
              begin
                rx_idx <= rx_idx + 4'h1;
                if (rx_idx == 4'd0 && rx_in)
                  rx_state <= SU_RX_IDLE; // False start
                else if (rx_idx >= 4'd1 && rx_idx <= `SU_DATA_BITS)
                  rx_shift_buffer[3'(rx_idx - 4'd1)] <= rx_in;
                else if (rx_idx == 4'd9 && ctrl.parity_on)
                  rx_par <= rx_in;
                if (rx_idx == rx_last)
                begin
                  rx_state <= SU_RX_IDLE;
                  rx_done <= 1'b1;
                  rx_fer_ev <= !rx_in; // [R15]
                  rx_per_ev <= ctrl.parity_on && par_bad;
                end
              end
            end
          end
          default: rx_state <= SU_RX_IDLE;
        endcase
      end
    end
  end

  // Status flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat <= `SU_RST_STAT;
      rx_holding_buffer <= `SU_RST_RXD;
    end
    else
    begin
      // Software clears by writing 0; a controller tx data write or rx data read clears too
      if ((wr_stat && !wdata_i[7]) || (wr_txd && xfer_clear))
      begin
        stat.tx_buffer_empty_flag <= 1'b0;
        stat.tx_finished_flag <= 1'b0; // [R9]
      end
      if ((wr_stat && !wdata_i[6]) || (rd_rxd && xfer_clear))
        stat.rx_full_flag <= 1'b0;
      // Writes clear faults, as can a newer faulty frame for framing or parity; never rx enable
      if (wr_stat && !wdata_i[5])
        stat.overrun_flag <= 1'b0; // [R19]
      if (wr_stat && !wdata_i[4])
        stat.framing_fault_flag <= 1'b0;
      if (wr_stat && !wdata_i[3])
        stat.parity_fault_flag <= 1'b0;
      if (stop || !ctrl.tx_on || tx_load || (tx_end
          && !stat.tx_buffer_empty_flag && !sync_blocked))
        stat.tx_buffer_empty_flag <= 1'b1; // [R11]
      if (tx_end && stat.tx_buffer_empty_flag)
        stat.tx_finished_flag <= 1'b1;
      if (rx_done)
      begin
        if (stat.rx_full_flag)
          stat.overrun_flag <= 1'b1; // [R13]
        else
        begin
          rx_holding_buffer <= rx_shift_buffer; // [R14]
          if (rx_fer_ev || rx_per_ev)
          begin
            stat.framing_fault_flag <= rx_fer_ev;
            stat.parity_fault_flag <= rx_per_ev;
          end
          else
            stat.rx_full_flag <= 1'b1;
        end
      end
    end
  end

  // Registered request lines, controller starts and top request code
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_o <= '0;
      xfer_start_o <= 2'b00;
      irq_top_o <= 3'h0;
    end
    else
    begin
      irq_o <= next_irq; // [R1] [R25]
      // Bit 1 from rx full, bit 0 from tx empty only
      xfer_start_o <= {next_irq.rx_full_irq,
                       next_irq.tx_empty_irq}; // [R6]
      if (next_irq.rx_fault_irq) // [R8]
        irq_top_o <= 3'h1;
      else if (next_irq.rx_full_irq)
        irq_top_o <= 3'h2;
      else if (next_irq.tx_empty_irq)
        irq_top_o <= 3'h3;
      else if (next_irq.tx_done_irq)
        irq_top_o <= 3'h4;
      else
        irq_top_o <= 3'h0;
    end
  end

endmodule

// ===== dv/su_checker.sv
/*
  Port checker for the serial unit's request lines.
  Assumes it is bound into su_serial_unit by the bind at the foot.
*/
`include "su_defines.svh"
module su_checker
  import su_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  // Controller qualifiers
  input wire logic xfer_access_i,
  input wire logic xfer_irq_select_i,
  input wire logic xfer_count_nonzero_i,
  // Requests
  input wire su_irq_s irq_o,
  input wire logic [1:0] xfer_start_o,
  input wire logic [2:0] irq_top_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Write strobe one cycle back; a read right behind a write is skipped
  logic wr_q;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wr_q <= 1'b0;
    else
      wr_q <= wr_i;
  end

  // Controller accesses that may clear a flag, and receive data reads
  wire dtc_clr = xfer_access_i && !xfer_irq_select_i && xfer_count_nonzero_i;
  wire rx_rd = rd_i && addr_i == `SU_OFS_RXD && !wr_q;

  a_start_src: assert property (
    xfer_start_o == {irq_o.rx_full_irq, irq_o.tx_empty_irq})
    else $error("controller start differs from request lines");
  a_done_clear: assert property (
    wr_i && addr_i == `SU_OFS_STAT && !wdata_i[7] |-> ##2 !irq_o.tx_done_irq)
    else $error("tx done request survived an empty flag clear");
  a_rx_dtc_clr: assert property (
    rx_rd && dtc_clr |-> ##2 !irq_o.rx_full_irq)
    else $error("controller read did not clear rx full");
  a_rx_dtc_keep: assert property (
    rx_rd && xfer_access_i && !dtc_clr && irq_o.rx_full_irq
      |-> ##2 irq_o.rx_full_irq)
    else $error("controller read cleared rx full wrongly");
  a_fault_hold: assert property (
    irq_o.rx_fault_irq && !wr_i && !$past(wr_i) |=> irq_o.rx_fault_irq)
    else $error("rx fault request dropped without a clear");
  a_top_fault: assert property (
    $stable(irq_o) && irq_o.rx_fault_irq |-> irq_top_o == 3'h1)
    else $error("rx fault not reported as top request");
  a_top_done: assert property (
    $stable(irq_o) && irq_o == 4'h1 |-> irq_top_o == 3'h4)
    else $error("lone tx done not reported as top request");
  a_top_none: assert property (
    $stable(irq_o) && irq_o == 4'h0 |-> irq_top_o == 3'h0)
    else $error("top request shown with no request pending");
endmodule

bind su_serial_unit su_checker u_chk (.ref_clk_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .xfer_access_i, .xfer_irq_select_i,
  .xfer_count_nonzero_i, .irq_o, .xfer_start_o, .irq_top_o);

// ===== dv/su_peer.sv
/*
  Serial peer: sends async frames, receives async frames, clocks sync bytes.
  Assumes a 64 ns bit time, the unit's divider set to its fastest.
*/
module su_peer (
  // Lines towards the unit
  output logic rxd_o,
  output logic sclk_o,
  input wire logic txd_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Mark idle; serial clock parked high outside frames
  initial
  begin
    rxd_o = 1'b1;
    sclk_o = 1'b1;
  end

  // Async frame: start, 8 data LSB first, optional parity, stop
  task automatic send(input logic [7:0] d, input logic pon, par, stp);
    rxd_o = 1'b0;
    #64;
    for (int i = 0; i < 8; i++)
    begin
      rxd_o = d[i];
      #64;
    end
    if (pon)
    begin
      rxd_o = par;
      #64;
    end
    rxd_o = stp;
    #64;
    rxd_o = 1'b1;
    #64;
  endtask

  // Bounded wait for a start bit, then mid-bit sampling
  task automatic recv(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 4000 && !ok; n++)
      #1 ok = (txd_i === 1'b0);
    #32;
    for (int i = 0; i < 8; i++)
    begin
      #64;
      d[i] = txd_i;
    end
    #64;
    ok = ok && txd_i;
  endtask

  // Sync byte: data moves after a fall, the unit samples on the rise
  task automatic clk_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      sclk_o = 1'b0;
      rxd_o = d[i];
      #32;
      sclk_o = 1'b1;
      #32;
    end
    rxd_o = ~d[7]; // Released line must not look like held data
  endtask
endmodule

// ===== dv/tb.sv
/*
  Self-checking bench for su_serial_unit with a serial peer.
  Assumes su_pkg, su_peer and su_checker are compiled before it.
*/
`include "su_defines.svh"
module tb;
  import su_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, wr, rd, xa, sel, nz, txd, rxd, sclk, ok;
  logic [2:0] addr, top;
  logic [7:0] wdata, rdata, q, d;
  logic [1:0] xs;
  su_irq_s irq;
  int mismatches, n_tests;

  su_serial_unit DUT (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .xfer_access_i(xa), .xfer_irq_select_i(sel),
    .xfer_count_nonzero_i(nz), .rxd_i(rxd), .sclk_i(sclk), .txd_o(txd),
    .irq_o(irq), .xfer_start_o(xs), .irq_top_o(top));
  su_peer peer (.rxd_o(rxd), .sclk_o(sclk), .txd_i(txd));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Settle a little past the edge so sampled outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] v,
    input logic x = 1'b0);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    xa <= x;
    @(posedge clk);
    wr <= 1'b0;
    xa <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] e,
    input logic x = 1'b0);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    xa <= x;
    @(posedge clk);
    rd <= 1'b0;
    xa <= 1'b0;
    @(posedge clk);
    chk(rdata, e);
  endtask

  // Even parity unless bad is set; line moves clear of the sampling edge
  task automatic rx(input logic [7:0] v, input logic bad, input logic stp);
    @(negedge clk);
    peer.send(v, 1'b1, (^v) ^ bad, stp);
    tick(4);
  endtask

  task automatic final_report;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    xa = 1'b0;
    sel = 1'b0;
    nz = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    void'($urandom(32'h1aee_666b));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(`SU_OFS_STAT, 8'h00);
    wreg(`SU_OFS_CTRL, 8'hff);
    wreg(`SU_OFS_STOP, 8'h00);
    rchk(`SU_OFS_CTRL, 8'h00);
    rchk(`SU_OFS_STAT, 8'h84);
    rchk(`SU_OFS_TXD, 8'hff);
    rchk(3'h7, 8'h00);
    wreg(`SU_OFS_PORT, 8'h00);
    tick(3);
    chk(txd, 8'h00);
    wreg(`SU_OFS_PORT, 8'h01);
    tick(3);
    chk(txd, 8'h01);
    wreg(`SU_OFS_CTRL, 8'ha4);
    tick(3);
    chk(irq, 8'h03);
    chk(xs, 8'h01);
    chk(top, 8'h03);
    // Controller write with select set leaves the empty flag alone
    d = 8'($urandom);
    sel <= 1'b1;
    wreg(`SU_OFS_TXD, d, 1'b1);
    sel <= 1'b0;
    rchk(`SU_OFS_STAT, 8'h84);
    rchk(`SU_OFS_TXD, d);
    // Back-to-back frames, the first one cleared by software
    for (int k = 0; k < 3; k++)
    begin
      d = 8'($urandom);
      fork
        peer.recv(q, ok);
        if (k == 0)
        begin
          wreg(`SU_OFS_TXD, d);
          wreg(`SU_OFS_STAT, 8'h7f);
          tick(1);
          chk(irq.tx_done_irq, 8'h00);
        end
        else
          wreg(`SU_OFS_TXD, d, 1'b1);
      join
      chk(q, d);
      chk(ok, 8'h01);
    end
    tick(20);
    chk(irq, 8'h03);
    wreg(`SU_OFS_CTRL, 8'h24);
    tick(3);
    chk(irq, 8'h01);
    chk(top, 8'h04);
    // Break: port low first, then transmit off in mid-frame
    wreg(`SU_OFS_CTRL, 8'h20);
    wreg(`SU_OFS_TXD, 8'hff);
    wreg(`SU_OFS_STAT, 8'h7f);
    tick(40);
    wreg(`SU_OFS_PORT, 8'h00);
    tick(1);
    chk(txd, 8'h01);
    wreg(`SU_OFS_CTRL, 8'h00);
    tick(3);
    chk(txd, 8'h00);
    tick(200);
    chk(txd, 8'h00);
    rchk(`SU_OFS_STAT, 8'h80);
    wreg(`SU_OFS_PORT, 8'h01);
    // Receive, then overrun on a second unread byte
    wreg(`SU_OFS_CTRL, 8'h52);
    d = 8'($urandom);
    rx(d, 1'b0, 1'b1);
    chk(irq, 8'h04);
    chk(xs, 8'h02);
    chk(top, 8'h02);
    rx(8'($urandom), 1'b0, 1'b1);
    rchk(`SU_OFS_STAT, 8'he0);
    chk(irq, 8'h0c);
    chk(top, 8'h01);
    rchk(`SU_OFS_RXD, d);
    sel <= 1'b1;
    rchk(`SU_OFS_RXD, d, 1'b1);
    sel <= 1'b0;
    rchk(`SU_OFS_STAT, 8'he0);
    rchk(`SU_OFS_RXD, d, 1'b1);
    rchk(`SU_OFS_STAT, 8'ha0);
    wreg(`SU_OFS_STAT, 8'hdf);
    tick(2);
    chk(irq, 8'h00);
    // Parity fault, framing fault, then two breaks
    for (int k = 0; k < 4; k++)
    begin
      d = (k > 1) ? 8'h00 : 8'($urandom);
      rx(d, k == 0, k == 0);
      rchk(`SU_OFS_STAT, (k == 0) ? 8'h88 : 8'h90);
      rchk(`SU_OFS_RXD, d);
      chk(irq, 8'h08);
      // A low stop bit restarts the receiver; cycling rx enable drops it
      if (k > 0)
      begin
        wreg(`SU_OFS_CTRL, 8'h42);
        if (k == 1)
          rchk(`SU_OFS_STAT, 8'h90);
        wreg(`SU_OFS_CTRL, 8'h52);
      end
      wreg(`SU_OFS_STAT, 8'he7);
    end
    // Sync mode: a pending fault holds off transmit and receive
    rx(8'h00, 1'b0, 1'b0);
    wreg(`SU_OFS_CTRL, 8'h31);
    wreg(`SU_OFS_TXD, 8'h3c);
    wreg(`SU_OFS_STAT, 8'h7f);
    tick(8);
    d = 8'($urandom);
    peer.clk_byte(d);
    tick(4);
    rchk(`SU_OFS_STAT, 8'h10);
    wreg(`SU_OFS_STAT, 8'hef);
    tick(8);
    peer.clk_byte(d);
    tick(6);
    rchk(`SU_OFS_RXD, d);
    final_report;
  end
endmodule
